// File: hw/zcps_pkg.sv
/*
  Shared constants and types for the zero-crossing period sampler.
  Assumes a 40 MHz core clock and a host bus with byte addresses and 16-bit data.
*/
package zcps_pkg;

   // Core clock and time base.
   localparam int CLK_PERIOD_NS = 25;
   localparam int TB_PERIOD_NS  = 250;
   localparam int TB_DIV        = TB_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 4;
   localparam logic [DIV_W-1:0] TB_DIV_LAST = DIV_W'(TB_DIV - 1);

   // Counter and capture geometry.
   localparam int CNT_W       = 16;
   localparam int NUM_PERIODS = 8;
   localparam int NUM_CAPS    = NUM_PERIODS - 1;
   localparam int IDX_W       = 3;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_CAPS);
   localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   // Register map, byte addresses.
   localparam int ADDR_W = 32;
   localparam logic [ADDR_W-1:0] CTRL_ADDR     = 32'h2900_0000;
   localparam logic [ADDR_W-1:0] CAP_BASE_ADDR = 32'h2900_0002;
   localparam logic [ADDR_W-1:0] CAP_STRIDE    = 32'h0000_0002;
   localparam logic [ADDR_W-1:0] FINAL_ADDR    = 32'h2900_0010;

   // Register decode results.
   localparam logic [3:0] SEL_CTRL  = 4'h8;
   localparam logic [3:0] SEL_FINAL = 4'h9;
   localparam logic [3:0] SEL_NONE  = 4'hf;

   // Control and status fields.
   localparam int CTRL_TB_EN_BIT = 0;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_OVF_BIT   = 1;
   localparam int DATA_W         = 16;

   typedef enum logic [1:0] {
      ZCPS_IDLE,
      ZCPS_ARM,
      ZCPS_MEASURE
   } zcps_state_t;

endpackage : zcps_pkg

// File: hw/zcps_cap_mem.sv
/*
  Small capture memory holding the first seven completed period counts.
  Assumes one write port and one read port on the same clock.
*/
`timescale 1ns/1ps
module zcps_cap_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 7,
   parameter int AW    = 3
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata_r
);

   logic [WIDTH-1:0] mem_r [DEPTH];

   // Cleared on reset so a read before the first sequence returns zero.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_r[i] <= '0;
         end
      end
      else if (we && (int'(waddr) < DEPTH))
      begin
         mem_r[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_r <= '0;
      else if (int'(raddr) < DEPTH)
         rdata_r <= mem_r[raddr];
      else
         rdata_r <= '0;
   end

endmodule : zcps_cap_mem

// File: hw/zcps_top.sv
/*
  Zero-crossing period sampler: times eight consecutive periods of a
  conditioned square wave in 250 ns steps and offers them to a host.
  Assumes a 40 MHz core clock, a synchronous active-high reset and a host
  bus that gives single-cycle read and write strobes with a byte address.
*/
`timescale 1ns/1ps
module zcps_top (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // Host bus
   input  wire logic [zcps_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [zcps_pkg::DATA_W-1:0] bus_wdata,
   input  wire logic                        bus_wr,
   input  wire logic                        bus_rd,
   output logic      [zcps_pkg::DATA_W-1:0] bus_rdata,
   output logic                             bus_rvalid,
   // Pins
   input  wire logic                        zero_cross_input_pin,
   output logic                             time_base_enable_pin
);

   zcps_pkg::zcps_state_t state_r;

   logic                         sync1_r;
   logic                         sync2_r;
   logic                         sync3_r;
   logic                         agree;
   logic                         filt_r;
   logic                         filt_prev_r;
   logic                         rise;
   logic                         ctrl_wr;
   logic                         busy;
   logic                         tb_en_r;
   logic [zcps_pkg::DIV_W-1:0]   div_r;
   logic                         tick;
   logic [zcps_pkg::CNT_W-1:0]   cnt_r;
   logic [zcps_pkg::IDX_W-1:0]   idx_r;
   logic                         ovf_r;
   logic                         cap_we;
   logic [zcps_pkg::DATA_W-1:0]  status_word;
   logic [3:0]                   rd_sel;
   logic                         rd_mem_r;
   logic                         rd_p1_r;
   logic [zcps_pkg::DATA_W-1:0]  local_q_r;
   logic [zcps_pkg::DATA_W-1:0]  mem_q;
   logic [zcps_pkg::IDX_W-1:0]   mem_raddr;
   logic [zcps_pkg::DATA_W-1:0]  rdata_r;
   logic                         rvalid_r;

   // Maps a byte address to a capture index, the control word, the final
   // count or nothing.
   function automatic logic [3:0] reg_decode(input logic [zcps_pkg::ADDR_W-1:0] a);
      logic [3:0] sel;
      sel = zcps_pkg::SEL_NONE;
      if (a == zcps_pkg::CTRL_ADDR)
         sel = zcps_pkg::SEL_CTRL;
      else if (a == zcps_pkg::FINAL_ADDR)
         sel = zcps_pkg::SEL_FINAL;
      else
      begin
         for (int i = 0; i < zcps_pkg::NUM_CAPS; i++)
         begin
            if (a == zcps_pkg::CAP_BASE_ADDR
                     + zcps_pkg::ADDR_W'(i) * zcps_pkg::CAP_STRIDE)
               sel = 4'(i);
         end
      end
      return sel;
   endfunction : reg_decode

   // Input conditioning. The first stage only feeds the second, so a
   // metastable sample never reaches the agreement compare.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end
      else
      begin
         sync1_r <= zero_cross_input_pin;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign agree = (sync2_r == sync3_r);

   always_ff @(posedge core_clk)
   begin
      if (rst)
         filt_r <= 1'b0;
      else if (agree)
         filt_r <= sync3_r;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         filt_prev_r <= 1'b0;
      else
         filt_prev_r <= filt_r;
   end

   assign rise = filt_r & ~filt_prev_r;

   // Control write: any write to the control address restarts, whatever data it carries.
   assign ctrl_wr = bus_wr && (reg_decode(bus_addr) == zcps_pkg::SEL_CTRL);
   assign busy    = (state_r != zcps_pkg::ZCPS_IDLE);

   always_ff @(posedge core_clk)
   begin
      if (rst)
         tb_en_r <= 1'b0;
      else if (ctrl_wr)
         tb_en_r <= bus_wdata[zcps_pkg::CTRL_TB_EN_BIT];
   end

   // The crystal is only powered during a sequence with bit zero set.
   assign time_base_enable_pin = tb_en_r & busy;

   // Time base: one enable pulse every 250 ns, restarted with the sequence
   // but not at each edge, so its phase against each period is free.
   always_ff @(posedge core_clk)
   begin
      if (rst || ctrl_wr || !time_base_enable_pin)
         div_r <= '0;
      else if (div_r == zcps_pkg::TB_DIV_LAST)
         div_r <= '0;
      else
         div_r <= div_r + 4'h1;
   end

   assign tick = time_base_enable_pin && (div_r == zcps_pkg::TB_DIV_LAST);

   // Sequencer.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         state_r <= zcps_pkg::ZCPS_IDLE;
      else if (ctrl_wr)
         state_r <= zcps_pkg::ZCPS_ARM;
      else
      begin
         unique case (state_r)
            zcps_pkg::ZCPS_IDLE:
               state_r <= zcps_pkg::ZCPS_IDLE;
            zcps_pkg::ZCPS_ARM:
               if (rise)
                  state_r <= zcps_pkg::ZCPS_MEASURE;
            zcps_pkg::ZCPS_MEASURE:
               if (rise && idx_r == zcps_pkg::IDX_LAST)
                  state_r <= zcps_pkg::ZCPS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst || ctrl_wr)
         idx_r <= '0;
      else if (cap_we)
         idx_r <= idx_r + 3'h1;
   end

   assign cap_we = !ctrl_wr && (state_r == zcps_pkg::ZCPS_MEASURE)
                   && rise && (idx_r != zcps_pkg::IDX_LAST);

   // Period counter. It saturates rather than wraps, so an overflowed
   // period reads as all ones and can never pass for a short period.
   always_ff @(posedge core_clk)
   begin
      if (rst || ctrl_wr)
         cnt_r <= zcps_pkg::CNT_ZERO;
      else if (state_r == zcps_pkg::ZCPS_ARM)
         cnt_r <= zcps_pkg::CNT_ZERO;
      else if (state_r == zcps_pkg::ZCPS_MEASURE)
      begin
         if (cap_we)
            cnt_r <= zcps_pkg::CNT_ZERO;
         else if (rise)
            cnt_r <= cnt_r;
         else if (tick && cnt_r != zcps_pkg::CNT_MAX)
            cnt_r <= cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst || ctrl_wr)
         ovf_r <= 1'b0;
      else if (state_r == zcps_pkg::ZCPS_MEASURE && tick && !rise
               && cnt_r == zcps_pkg::CNT_MAX)
         ovf_r <= 1'b1;
   end

   always_comb
   begin
      status_word = '0;
      status_word[zcps_pkg::STAT_BUSY_BIT] = busy;
      status_word[zcps_pkg::STAT_OVF_BIT]  = ovf_r;
   end

   zcps_cap_mem #(
      .WIDTH (zcps_pkg::CNT_W),
      .DEPTH (zcps_pkg::NUM_CAPS),
      .AW    (zcps_pkg::IDX_W)
   ) u_cap_mem (
      .clk     (core_clk),
      .rst     (rst),
      .we      (cap_we),
      .waddr   (idx_r),
      .wdata   (cnt_r),
      .raddr   (mem_raddr),
      .rdata_r (mem_q)
   );

   // Read path: decode and fetch in the first cycle, answer in the second.
   assign rd_sel    = reg_decode(bus_addr);
   assign mem_raddr = rd_sel[zcps_pkg::IDX_W-1:0];

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rd_p1_r   <= 1'b0;
         rd_mem_r  <= 1'b0;
         local_q_r <= '0;
      end
      else
      begin
         rd_p1_r  <= bus_rd;
         rd_mem_r <= bus_rd && (rd_sel < 4'(zcps_pkg::NUM_CAPS));
         if (rd_sel == zcps_pkg::SEL_CTRL)
            local_q_r <= status_word;
         else if (rd_sel == zcps_pkg::SEL_FINAL)
            local_q_r <= cnt_r;
         else
            local_q_r <= '0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= rd_p1_r;
         if (rd_p1_r)
            rdata_r <= rd_mem_r ? mem_q : local_q_r;
      end
   end

   assign bus_rdata  = rdata_r;
   assign bus_rvalid = rvalid_r;

   property p_start_arms;
      @(posedge core_clk) disable iff (rst)
      ctrl_wr |=> (state_r == zcps_pkg::ZCPS_ARM) && idx_r == 3'h0 && !ovf_r;
   endproperty
   a_start_arms: assert property (p_start_arms)
      else $error("control write did not restart the sequence");

   property p_hold_clear;
      @(posedge core_clk) disable iff (rst)
      (state_r == zcps_pkg::ZCPS_ARM) && !rise && !ctrl_wr |=> cnt_r == 16'h0000;
   endproperty
   a_hold_clear: assert property (p_hold_clear)
      else $error("counter moved before the first edge");

   property p_capture;
      @(posedge core_clk) disable iff (rst)
      cap_we |-> ##1 (cnt_r == 16'h0000) && (idx_r == $past(idx_r) + 3'h1);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not clear the counter and advance");

   property p_stop;
      @(posedge core_clk) disable iff (rst)
      (state_r == zcps_pkg::ZCPS_MEASURE) && rise && idx_r == 3'h7 && !ctrl_wr
      |=> !busy ##1 ($past(ctrl_wr) || $stable(cnt_r));
   endproperty
   a_stop: assert property (p_stop)
      else $error("counter did not stop after the eighth period");

   property p_step;
      @(posedge core_clk) disable iff (rst)
      (state_r == zcps_pkg::ZCPS_MEASURE) && tick && !rise && !ctrl_wr
      && cnt_r != 16'hffff |=> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step on the time base");

   property p_tick_rate;
      @(posedge core_clk) disable iff (rst)
      tick && !ctrl_wr |=> !tick throughout (##8 1'b1);
   endproperty
   a_tick_rate: assert property (p_tick_rate)
      else $error("time base pulse spacing wrong");

   property p_busy_bit;
      @(posedge core_clk) disable iff (rst)
      rd_sel == zcps_pkg::SEL_CTRL && bus_rd |-> ##2 bus_rvalid && bus_rdata[0] == $past(busy, 2);
   endproperty
   a_busy_bit: assert property (p_busy_bit)
      else $error("busy bit does not follow the sequencer");

   property p_ovf_set;
      @(posedge core_clk) disable iff (rst)
      (state_r == zcps_pkg::ZCPS_MEASURE) && tick && !rise && !ctrl_wr
      && cnt_r == 16'hffff |=> ovf_r && cnt_r == 16'hffff;
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow not flagged or counter wrapped");

   property p_ovf_sticky;
      @(posedge core_clk) disable iff (rst)
      ovf_r && !ctrl_wr |=> ovf_r;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("overflow flag cleared without a start write");

   property p_filter;
      @(posedge core_clk) disable iff (rst)
      (filt_r != $past(filt_r)) |-> $past(agree);
   endproperty
   a_filter: assert property (p_filter)
      else $error("filtered input changed without agreement");

   property p_edge;
      @(posedge core_clk) disable iff (rst)
      $rose(filt_r) |-> rise ##1 !rise;
   endproperty
   a_edge: assert property (p_edge)
      else $error("rising edge pulse missing or too long");

   property p_pin_idle;
      @(posedge core_clk) disable iff (rst)
      (state_r == zcps_pkg::ZCPS_IDLE) |-> !time_base_enable_pin;
   endproperty
   a_pin_idle: assert property (p_pin_idle)
      else $error("time base left on while idle");

endmodule : zcps_top

// File: tb/zcps_host_model.sv
/*
  Host bus master model for the period sampler: single-cycle strobes launched
  on the falling clock edge, plus a completion-poll helper.
  Assumes the read answer arrives within four falling edges after the read strobe ends.
*/
`timescale 1ns/1ps
module zcps_host_model (
   // Clock
   input  wire logic                        core_clk,
   // Host bus
   output logic      [zcps_pkg::ADDR_W-1:0] bus_addr,
   output logic      [zcps_pkg::DATA_W-1:0] bus_wdata,
   output logic                             bus_wr,
   output logic                             bus_rd,
   input  wire logic [zcps_pkg::DATA_W-1:0] bus_rdata,
   input  wire logic                        bus_rvalid
);
   initial
   begin
      bus_addr  = 32'h0000_0000;
      bus_wdata = 16'h0000;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
   end

   // A released bus shows the inverse of its last value, so nothing stale can match.
   task automatic write_reg(input logic [31:0] addr, input logic [15:0] data);
      @(negedge core_clk);
      bus_addr  = addr;
      bus_wdata = data;
      bus_wr    = 1'b1;
      @(negedge core_clk);
      bus_wr    = 1'b0;
      bus_addr  = ~addr;
      bus_wdata = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [31:0] addr, output logic [15:0] data);
      int n;
      @(negedge core_clk);
      bus_addr = addr;
      bus_rd   = 1'b1;
      @(negedge core_clk);
      bus_rd   = 1'b0;
      bus_addr = ~addr;
      data     = 16'hxxxx;
      for (n = 0; n < 4; n++)
      begin
         @(negedge core_clk);
         if (bus_rvalid === 1'b1)
         begin
            data = bus_rdata;
            break;
         end
      end
   endtask : read_reg

   // Captured values are only trusted after busy has been seen low.
   task automatic wait_done(output logic [15:0] st);
      int n;
      st = 16'hxxxx;
      for (n = 0; n < 200; n++)
      begin
         read_reg(zcps_pkg::CTRL_ADDR, st);
         if (st[zcps_pkg::STAT_BUSY_BIT] === 1'b0)
            break;
      end
   endtask : wait_done
endmodule : zcps_host_model

// File: tb/test_zcps_top.sv
/*
  Self-checking bench for the period sampler: drives the zero-crossing pin
  and talks to the registers through the host model.
  Assumes the overflow path cannot be reached in a short run (a 16-bit count
  of 250 ns steps needs over 650000 clocks), so it is left untested.
*/
`timescale 1ns/1ps
module test_zcps_top;
   logic        core_clk;
   logic        rst;
   logic [31:0] bus_addr;
   logic [15:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [15:0] bus_rdata;
   logic        bus_rvalid;
   logic        zero_cross_input_pin;
   logic        time_base_enable_pin;
   logic [15:0] v;
   int          mismatches;
   int          checks;
   int          ks[8] = '{3, 4, 5, 6, 7, 8, 9, 10};

   zcps_top dut (
      .core_clk             (core_clk),
      .rst                  (rst),
      .bus_addr             (bus_addr),
      .bus_wdata            (bus_wdata),
      .bus_wr               (bus_wr),
      .bus_rd               (bus_rd),
      .bus_rdata            (bus_rdata),
      .bus_rvalid           (bus_rvalid),
      .zero_cross_input_pin (zero_cross_input_pin),
      .time_base_enable_pin (time_base_enable_pin)
   );

   zcps_host_model host (
      .core_clk   (core_clk),
      .bus_addr   (bus_addr),
      .bus_wdata  (bus_wdata),
      .bus_wr     (bus_wr),
      .bus_rd     (bus_rd),
      .bus_rdata  (bus_rdata),
      .bus_rvalid (bus_rvalid)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_rd(input logic [31:0] addr, input logic [15:0] exp);
      host.read_reg(addr, v);
      check(v, exp);
   endtask : check_rd

   // The tick phase against the edge is free, so a period may lose one step.
   task automatic check_near(input logic [31:0] addr, input logic [15:0] k);
      host.read_reg(addr, v);
      checks++;
      if (v !== k && v !== k - 16'h0001)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, v, k);
      end
   endtask : check_near

   // One rising edge followed by a period of 2*half clocks; g adds a 1-cycle spike.
   task automatic rise(input int half, input bit g);
      @(negedge core_clk);
      zero_cross_input_pin = 1'b1;
      repeat (half) @(negedge core_clk);
      zero_cross_input_pin = 1'b0;
      if (g)
      begin
         repeat (2) @(negedge core_clk);
         zero_cross_input_pin = 1'b1;
         @(negedge core_clk);
         zero_cross_input_pin = 1'b0;
         repeat (half - 4) @(negedge core_clk);
      end
      else
         repeat (half - 1) @(negedge core_clk);
   endtask : rise

   function automatic logic [31:0] cap_addr(input int i);
      return zcps_pkg::CAP_BASE_ADDR + zcps_pkg::CAP_STRIDE * 32'(i);
   endfunction : cap_addr

   initial
   begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      give_verdict();
   end

   initial
   begin
      mismatches           = 0;
      checks               = 0;
      rst                  = 1'b1;
      zero_cross_input_pin = 1'b0;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      check({15'h0000, time_base_enable_pin}, 16'h0000);
      check_rd(zcps_pkg::CTRL_ADDR, 16'h0000);
      check_rd(cap_addr(0), 16'h0000);
      check_rd(32'h2900_0020, 16'h0000);

      // Full sequence with a spike that the input filter must swallow.
      host.write_reg(zcps_pkg::CTRL_ADDR, 16'h0001);
      repeat (30) @(negedge core_clk);
      check({15'h0000, time_base_enable_pin}, 16'h0001);
      check_rd(zcps_pkg::CTRL_ADDR, 16'h0001);
      check_rd(zcps_pkg::FINAL_ADDR, 16'h0000);
      for (int i = 0; i < 8; i++)
         rise(5 * ks[i], i == 2);
      rise(5, 1'b0);
      host.wait_done(v);
      check(v, 16'h0000);
      check({15'h0000, time_base_enable_pin}, 16'h0000);
      for (int i = 0; i < 7; i++)
         check_near(cap_addr(i), 16'(ks[i]));
      check_near(zcps_pkg::FINAL_ADDR, 16'(ks[7]));
      rise(50, 1'b0);
      check_near(zcps_pkg::FINAL_ADDR, 16'(ks[7]));

      // Restart in mid-sequence abandons the old one.
      host.write_reg(zcps_pkg::CTRL_ADDR, 16'h0001);
      repeat (3) rise(25, 1'b0);
      host.write_reg(zcps_pkg::CTRL_ADDR, 16'h0001);
      check_rd(zcps_pkg::FINAL_ADDR, 16'h0000);
      check_rd(zcps_pkg::CTRL_ADDR, 16'h0001);
      repeat (9) rise(20, 1'b0);
      host.wait_done(v);
      check(v, 16'h0000);
      check_near(cap_addr(0), 16'h0004);

      // Time base off: the sequence still runs but never counts.
      host.write_reg(zcps_pkg::CTRL_ADDR, 16'h0000);
      check({15'h0000, time_base_enable_pin}, 16'h0000);
      check_rd(zcps_pkg::CTRL_ADDR, 16'h0001);
      repeat (9) rise(20, 1'b0);
      host.wait_done(v);
      check(v, 16'h0000);
      check_rd(cap_addr(6), 16'h0000);
      check_rd(zcps_pkg::FINAL_ADDR, 16'h0000);
      host.write_reg(cap_addr(0), 16'hffff);
      check_rd(cap_addr(0), 16'h0000);
      give_verdict();
   end
endmodule : test_zcps_top
